// ===== hbp_pkg.sv
// Shared constants for the parallel host register port and its controller
package hbp_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int PIN_W = ADDR_W + DATA_W + 3;

	// Device register indices
	localparam logic [12:0] REG_INT_STATUS = 13'h0000;
	localparam logic [12:0] REG_INT_MASK   = 13'h0001;
	localparam logic [12:0] REG_CLK_CFG    = 13'h0002;
	localparam logic [12:0] REG_CLK_TICKS  = 13'h0003;

	// Interrupt status and mask fields
	localparam int INT_FRAMER_BIT = 0;
	localparam int INT_LIU_BIT    = 1;
	localparam int INT_BERT_BIT   = 2;
	localparam int MASK_GLOBAL_BIT = 7;
	localparam logic [7:0] INT_EVENT_FIELDS = 8'h07;
	localparam logic [7:0] INT_MASK_RST   = 8'h00;

	// Clock configuration fields
	localparam int CFG_PS0_BIT    = 0;
	localparam int CFG_PS1_BIT    = 1;
	localparam int CFG_FAMILY_BIT = 2;
	localparam int CFG_TARGET_BIT = 3;
	localparam logic [7:0] CLK_CFG_RST = 8'h00;

	// Phase steps over a 16-bit accumulator
	localparam logic [17:0] STEP_ONE      = 18'h10000;
	localparam logic [17:0] STEP_E1_TO_T1 = 18'h0c100;
	localparam logic [17:0] STEP_T1_TO_E1 = 18'h15390;

	// Controller strobe timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETUP_NS  = 30;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS   = 40;
	localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Controller register indices and fields
	localparam logic [3:0] HREG_ADDR_LO  = 4'h0;
	localparam logic [3:0] HREG_ADDR_HI  = 4'h1;
	localparam logic [3:0] HREG_WDATA    = 4'h2;
	localparam logic [3:0] HREG_CMD      = 4'h3;
	localparam logic [3:0] HREG_STATUS   = 4'h4;
	localparam logic [3:0] HREG_RDATA    = 4'h5;
	localparam logic [3:0] HREG_IRQ_STAT = 4'h6;
	localparam logic [3:0] HREG_IRQ_MASK = 4'h7;
	localparam logic [3:0] HREG_CFG      = 4'h8;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT  = 1;
	localparam int HIRQ_DONE_BIT = 0;
	localparam int HIRQ_DEV_BIT  = 1;

	typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD} hbp_host_state_t;
endpackage

// ===== hbp_if.sv
// Pin-level connection between the register port and its controller
`timescale 1ns/1ps
interface hbp_if;
	logic [12:0] addr;
	logic [7:0]  host_data_o;
	logic        host_data_oe;
	logic [7:0]  dev_data_o;
	logic        dev_data_oe;
	logic        chip_select_n;
	logic        read_or_data_strobe_n;
	logic        write_or_rw_select_n;
	logic        bus_style_select;
	logic        int_drive_o;
	logic        int_drive_oe;
	logic [7:0]  data_bus;
	logic        interrupt_out_n;

	// Undriven lines read as pulled up
	assign data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hff);
	assign interrupt_out_n = int_drive_oe ? int_drive_o : 1'b1;

	modport dev (
		input  addr, data_bus, chip_select_n, read_or_data_strobe_n,
		input  write_or_rw_select_n, bus_style_select,
		output dev_data_o, dev_data_oe, int_drive_o, int_drive_oe
	);
	modport host (
		output addr, host_data_o, host_data_oe, chip_select_n,
		output read_or_data_strobe_n, write_or_rw_select_n, bus_style_select,
		input  data_bus, interrupt_out_n
	);
endinterface

// ===== hbp_sync.sv
// Two-stage synchroniser for a vector of pins
`timescale 1ns/1ps
module hbp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= '1;
			q        <= '1;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ===== hbp_device.sv
// Register port end: strobe decode, interrupt registers and master clock adapter
`timescale 1ns/1ps
module hbp_device (
	// Clock and reset
	input  wire logic  core_clk,
	input  wire logic  sys_rst,
	// Pins
	hbp_if.dev         bus,
	// Event inputs, one-cycle pulses
	input  wire logic  framer_event,
	input  wire logic  liu_event,
	input  wire logic  bert_event,
	// Clock configuration and derived rate
	output logic       master_prescale_sel0,
	output logic       master_prescale_sel1,
	output logic       master_family_select,
	output logic       derived_tick
);
	localparam int AW = hbp_pkg::ADDR_W;
	localparam int DW = hbp_pkg::DATA_W;

	logic [hbp_pkg::PIN_W-1:0] pins_s;
	logic [AW-1:0] addr_s;
	logic [DW-1:0] data_s;
	logic          cs_n_s;
	logic          rds_n_s;
	logic          wrs_n_s;
	logic          rd_act;
	logic          wr_act;
	logic          commit;

	logic          style_reg, style_next;
	logic          wr_prev_reg, wr_prev_next;
	logic [AW-1:0] waddr_reg, waddr_next;
	logic [DW-1:0] wdata_reg, wdata_next;
	logic [DW-1:0] dout_reg, dout_next;
	logic          doe_reg, doe_next;
	logic [DW-1:0] status_reg, status_next;
	logic [DW-1:0] mask_reg, mask_next;
	logic [DW-1:0] cfg_reg, cfg_next;
	logic          int_reg, int_next;
	logic [15:0]   acc_reg, acc_next;
	logic          tick_reg, tick_next;
	logic [DW-1:0] ticks_reg, ticks_next;
	logic [17:0]   sum;

	// Phase step for the selected master family, multiple and target rate
	function automatic logic [17:0] phase_step(input logic [DW-1:0] cfg);
		logic [17:0] base;
		base = hbp_pkg::STEP_ONE;
		if (cfg[hbp_pkg::CFG_FAMILY_BIT] != cfg[hbp_pkg::CFG_TARGET_BIT]) begin
			base = cfg[hbp_pkg::CFG_FAMILY_BIT] ? hbp_pkg::STEP_T1_TO_E1 : hbp_pkg::STEP_E1_TO_T1;
		end
		return base >> {cfg[hbp_pkg::CFG_PS1_BIT], cfg[hbp_pkg::CFG_PS0_BIT]};
	endfunction

	// Address and data ride through the same stages so they stay aligned with strobes
	hbp_sync #(
		.WIDTH(hbp_pkg::PIN_W)
	) u_sync (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.d       ({bus.addr, bus.data_bus, bus.chip_select_n,
		           bus.read_or_data_strobe_n, bus.write_or_rw_select_n}),
		.q       (pins_s)
	);

	assign addr_s  = pins_s[hbp_pkg::PIN_W-1 -: AW];
	assign data_s  = pins_s[DW+2:3];
	assign cs_n_s  = pins_s[2];
	assign rds_n_s = pins_s[1];
	assign wrs_n_s = pins_s[0];

	// Strobe decode
	always_comb begin
		if (style_reg) begin
			rd_act = !cs_n_s && !rds_n_s && wrs_n_s;
			wr_act = !cs_n_s && !rds_n_s && !wrs_n_s;
		end else begin
			rd_act = !cs_n_s && !rds_n_s;
			wr_act = !cs_n_s && !wrs_n_s;
		end
	end

	assign commit = wr_prev_reg && !wr_act;

	// Strap followed only between accesses so one access is never decoded two ways
	always_comb begin
		style_next = style_reg;
		if (cs_n_s && !wr_prev_reg) begin
			style_next = bus.bus_style_select;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			style_reg <= 1'b0;
		end else begin
			style_reg <= style_next;
		end
	end

	// Bus access
	always_comb begin
		wr_prev_next = wr_act;
		waddr_next   = waddr_reg;
		wdata_next   = wdata_reg;
		if (wr_act) begin
			waddr_next = addr_s;
			wdata_next = data_s;
		end
		doe_next  = rd_act;
		dout_next = 8'h00;
		case (addr_s)
			hbp_pkg::REG_INT_STATUS: dout_next = status_reg;
			hbp_pkg::REG_INT_MASK:   dout_next = mask_reg;
			hbp_pkg::REG_CLK_CFG:    dout_next = cfg_reg;
			hbp_pkg::REG_CLK_TICKS:  dout_next = ticks_reg;
			default:                 dout_next = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_prev_reg <= 1'b0;
			waddr_reg   <= '0;
			wdata_reg   <= '0;
			doe_reg     <= 1'b0;
			dout_reg    <= '0;
		end else begin
			wr_prev_reg <= wr_prev_next;
			waddr_reg   <= waddr_next;
			wdata_reg   <= wdata_next;
			doe_reg     <= doe_next;
			dout_reg    <= dout_next;
		end
	end

	// Registers and interrupt
	always_comb begin
		logic [DW-1:0] events;
		logic [DW-1:0] clr;
		events = 8'h00;
		events[hbp_pkg::INT_FRAMER_BIT] = framer_event;
		events[hbp_pkg::INT_LIU_BIT]    = liu_event;
		events[hbp_pkg::INT_BERT_BIT]   = bert_event;
		clr       = 8'h00;
		mask_next = mask_reg;
		cfg_next  = cfg_reg;
		if (commit) begin
			case (waddr_reg)
				hbp_pkg::REG_INT_STATUS: clr = wdata_reg;
				hbp_pkg::REG_INT_MASK:   mask_next = wdata_reg;
				hbp_pkg::REG_CLK_CFG:    cfg_next = wdata_reg;
				default:                 clr = 8'h00;
			endcase
		end
		// A new event wins over a clear in the same cycle
		status_next = ((status_reg & ~clr) | events) & hbp_pkg::INT_EVENT_FIELDS;
		int_next = mask_reg[hbp_pkg::MASK_GLOBAL_BIT]
			&& |(status_reg & mask_reg & hbp_pkg::INT_EVENT_FIELDS);
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_reg <= '0;
			mask_reg   <= hbp_pkg::INT_MASK_RST;
			cfg_reg    <= hbp_pkg::CLK_CFG_RST;
			int_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			cfg_reg    <= cfg_next;
			int_reg    <= int_next;
		end
	end

	// Rate adapter; core_clk stands for the master clock, keeps it in a known family
	assign sum = {2'b00, acc_reg} + phase_step(cfg_reg);

	always_comb begin
		acc_next   = sum[15:0];
		tick_next  = |sum[17:16];
		ticks_next = tick_next ? ticks_reg + 8'h01 : ticks_reg;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_reg   <= '0;
			tick_reg  <= 1'b0;
			ticks_reg <= '0;
		end else begin
			acc_reg   <= acc_next;
			tick_reg  <= tick_next;
			ticks_reg <= ticks_next;
		end
	end

	assign bus.dev_data_o       = dout_reg;
	assign bus.dev_data_oe      = doe_reg;
	assign bus.int_drive_o      = 1'b0;
	assign bus.int_drive_oe     = int_reg;
	assign master_prescale_sel0 = cfg_reg[hbp_pkg::CFG_PS0_BIT];
	assign master_prescale_sel1 = cfg_reg[hbp_pkg::CFG_PS1_BIT];
	assign master_family_select = cfg_reg[hbp_pkg::CFG_FAMILY_BIT];
	assign derived_tick         = tick_reg;
endmodule

// ===== hbp_host.sv
// Controller end: drives register port pins from its own command registers
`timescale 1ns/1ps
module hbp_host (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Pins
	hbp_if.host             bus,
	// Software register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Interrupt
	output logic            irq
);
	hbp_pkg::hbp_host_state_t state_reg, state_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic        is_read_reg, is_read_next;
	logic [12:0] addr_reg, addr_next;
	logic [7:0]  wdata_reg, wdata_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic [1:0]  irqs_reg, irqs_next;
	logic [1:0]  irqm_reg, irqm_next;
	logic        style_reg, style_next;
	logic [7:0]  rout_reg, rout_next;
	logic        irq_reg, irq_next;
	logic        cs_n_reg, cs_n_next;
	logic        rds_n_reg, rds_n_next;
	logic        wrs_n_reg, wrs_n_next;
	logic        doe_reg, doe_next;
	logic        dev_int_reg;

	always_comb begin
		logic [1:0] ev;
		logic [1:0] clr;
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		is_read_next = is_read_reg;
		addr_next    = addr_reg;
		wdata_next   = wdata_reg;
		rdata_next   = rdata_reg;
		irqm_next    = irqm_reg;
		style_next   = style_reg;
		ev  = 2'b00;
		clr = 2'b00;
		ev[hbp_pkg::HIRQ_DEV_BIT] = dev_int_reg;
		if (reg_wr) begin
			case (reg_addr)
				hbp_pkg::HREG_ADDR_LO:  addr_next[7:0] = reg_wdata;
				hbp_pkg::HREG_ADDR_HI:  addr_next[12:8] = reg_wdata[4:0];
				hbp_pkg::HREG_WDATA:    wdata_next = reg_wdata;
				hbp_pkg::HREG_IRQ_STAT: clr = reg_wdata[1:0];
				hbp_pkg::HREG_IRQ_MASK: irqm_next = reg_wdata[1:0];
				hbp_pkg::HREG_CFG:      style_next = reg_wdata[0];
				default:                clr = 2'b00;
			endcase
		end
		case (state_reg)
			hbp_pkg::HS_IDLE: begin
				// Commands arriving while busy are dropped
				if (reg_wr && reg_addr == hbp_pkg::HREG_CMD
					&& (reg_wdata[hbp_pkg::CMD_WRITE_BIT] || reg_wdata[hbp_pkg::CMD_READ_BIT])) begin
					is_read_next = reg_wdata[hbp_pkg::CMD_READ_BIT];
					state_next   = hbp_pkg::HS_SETUP;
					cnt_next     = 4'(hbp_pkg::SETUP_CYC - 1);
				end
			end
			hbp_pkg::HS_SETUP: begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h0) begin
					state_next = hbp_pkg::HS_STROBE;
					cnt_next   = 4'(hbp_pkg::STROBE_CYC - 1);
				end
			end
			hbp_pkg::HS_STROBE: begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h0) begin
					if (is_read_reg) begin
						rdata_next = bus.data_bus;
					end
					state_next = hbp_pkg::HS_HOLD;
					cnt_next   = 4'(hbp_pkg::HOLD_CYC - 1);
				end
			end
			hbp_pkg::HS_HOLD: begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h0) begin
					state_next = hbp_pkg::HS_IDLE;
					ev[hbp_pkg::HIRQ_DONE_BIT] = 1'b1;
				end
			end
			default: state_next = hbp_pkg::HS_IDLE;
		endcase
		irqs_next = (irqs_reg & ~clr) | ev;
		irq_next  = |(irqs_reg & irqm_reg);
		// Pin levels for the next cycle
		cs_n_next  = (state_next == hbp_pkg::HS_IDLE);
		doe_next   = !is_read_next && state_next != hbp_pkg::HS_IDLE;
		rds_n_next = 1'b1;
		wrs_n_next = 1'b1;
		if (style_reg) begin
			wrs_n_next = is_read_next || state_next == hbp_pkg::HS_IDLE;
			rds_n_next = state_next != hbp_pkg::HS_STROBE;
		end else if (state_next == hbp_pkg::HS_STROBE) begin
			rds_n_next = !is_read_next;
			wrs_n_next = is_read_next;
		end
		rout_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				hbp_pkg::HREG_ADDR_LO:  rout_next = addr_reg[7:0];
				hbp_pkg::HREG_ADDR_HI:  rout_next = {3'h0, addr_reg[12:8]};
				hbp_pkg::HREG_WDATA:    rout_next = wdata_reg;
				hbp_pkg::HREG_STATUS:   rout_next = {7'h00, state_reg != hbp_pkg::HS_IDLE};
				hbp_pkg::HREG_RDATA:    rout_next = rdata_reg;
				hbp_pkg::HREG_IRQ_STAT: rout_next = {6'h00, irqs_reg};
				hbp_pkg::HREG_IRQ_MASK: rout_next = {6'h00, irqm_reg};
				hbp_pkg::HREG_CFG:      rout_next = {7'h00, style_reg};
				default:                rout_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg   <= hbp_pkg::HS_IDLE;
			cnt_reg     <= '0;
			is_read_reg <= 1'b0;
			addr_reg    <= '0;
			wdata_reg   <= '0;
			rdata_reg   <= '0;
			irqs_reg    <= '0;
			irqm_reg    <= '0;
			style_reg   <= 1'b0;
			rout_reg    <= '0;
			irq_reg     <= 1'b0;
			cs_n_reg    <= 1'b1;
			rds_n_reg   <= 1'b1;
			wrs_n_reg   <= 1'b1;
			doe_reg     <= 1'b0;
			dev_int_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			is_read_reg <= is_read_next;
			addr_reg    <= addr_next;
			wdata_reg   <= wdata_next;
			rdata_reg   <= rdata_next;
			irqs_reg    <= irqs_next;
			irqm_reg    <= irqm_next;
			style_reg   <= style_next;
			rout_reg    <= rout_next;
			irq_reg     <= irq_next;
			cs_n_reg    <= cs_n_next;
			rds_n_reg   <= rds_n_next;
			wrs_n_reg   <= wrs_n_next;
			doe_reg     <= doe_next;
			dev_int_reg <= !bus.interrupt_out_n;
		end
	end

	assign bus.addr                  = addr_reg;
	assign bus.host_data_o           = wdata_reg;
	assign bus.host_data_oe          = doe_reg;
	assign bus.chip_select_n         = cs_n_reg;
	assign bus.read_or_data_strobe_n = rds_n_reg;
	assign bus.write_or_rw_select_n  = wrs_n_reg;
	assign bus.bus_style_select      = style_reg;
	assign reg_rdata                 = rout_reg;
	assign irq                       = irq_reg;
endmodule

// ===== hbp_sva.sv
// Pin-level assertions on the link between controller and register port
`timescale 1ns/1ps
module hbp_sva (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Link pins
	input  wire logic [12:0] addr,
	input  wire logic        host_data_oe,
	input  wire logic        dev_data_oe,
	input  wire logic        chip_select_n,
	input  wire logic        read_or_data_strobe_n,
	input  wire logic        write_or_rw_select_n,
	input  wire logic        bus_style_select,
	input  wire logic [7:0]  data_bus,
	input  wire logic        interrupt_out_n
);
	logic       cs;
	logic       rd;
	logic       wr;
	logic       rd_act;
	logic       wr_act;
	logic       wr_reg;
	logic [3:0] since_wr_reg;
	logic [3:0] since_wr_next;

	assign cs = !chip_select_n;
	assign rd = !read_or_data_strobe_n;
	assign wr = !write_or_rw_select_n;
	// Data-strobe style (bus_style_select high): data strobe qualified by the read/write select
	assign rd_act = cs && rd && !(bus_style_select && wr);
	assign wr_act = cs && (bus_style_select ? rd : 1'b1) && wr;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// Cycles since a write strobe ended, saturating
	always_comb begin
		since_wr_next = since_wr_reg;
		if (wr_reg && !wr_act)
			since_wr_next = 4'h0;
		else if (since_wr_reg != 4'hf)
			since_wr_next = since_wr_reg + 4'h1;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_reg       <= 1'b0;
			since_wr_reg <= 4'hf;
		end else begin
			wr_reg       <= wr_act;
			since_wr_reg <= since_wr_next;
		end
	end

	sequence wr_low_s;
		wr_act [*8];
	endsequence
	sequence wr_hold_s;
		(!wr_act && cs) [*4];
	endsequence

	AST_CS_QUALIFIES: assert property ((rd || wr) |-> cs)
		else $error("strobe seen without chip select");
	AST_READ_DRIVE: assert property ($rose(rd_act) |-> ##3 dev_data_oe)
		else $error("read data not driven three cycles after strobe");
	AST_READ_RELEASE: assert property ($fell(rd_act) && dev_data_oe |-> dev_data_oe [*3] ##1 !dev_data_oe)
		else $error("read data not released three cycles after strobe");
	AST_DRIVE_CAUSE: assert property (dev_data_oe |-> $past(rd_act, 3))
		else $error("data bus driven without selected read");
	AST_NO_CLASH: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the data bus");
	AST_WRITE_CYCLE: assert property ($rose(wr_act) |-> wr_low_s ##1 wr_hold_s ##1 !cs)
		else $error("write strobe or hold length wrong");
	AST_WRITE_DATA: assert property (wr_act |-> host_data_oe && $stable(data_bus))
		else $error("write data not steady under strobe");
	AST_ADDR_HELD: assert property (cs && $past(cs) |-> $stable(addr))
		else $error("address moved during access");
	AST_STYLE_STEADY: assert property (cs |-> $stable(bus_style_select))
		else $error("bus style changed during access");
	AST_INT_RELEASE: assert property ($rose(interrupt_out_n) |-> since_wr_reg <= 4'h6)
		else $error("interrupt released without a clearing write");
endmodule

// ===== tb_top.sv
// Self-checking bench for the register port and its controller
`timescale 1ns/1ps
module tb_top;
	logic       core_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       irq;
	logic [2:0] ev = 3'h0;
	logic [2:0] cfg_pins;
	logic       derived_tick;
	logic [7:0] q;
	int         fails = 0;
	int         total_checks = 0;

	hbp_if bus_if ();
	hbp_host hbp_host_inst (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus_if), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	hbp_device hbp_device_inst (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus_if), .framer_event(ev[0]),
		.liu_event(ev[1]), .bert_event(ev[2]), .master_prescale_sel0(cfg_pins[0]),
		.master_prescale_sel1(cfg_pins[1]), .master_family_select(cfg_pins[2]), .derived_tick(derived_tick));
	hbp_sva hbp_sva_inst (.core_clk(core_clk), .sys_rst(sys_rst), .addr(bus_if.addr),
		.host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe),
		.chip_select_n(bus_if.chip_select_n), .read_or_data_strobe_n(bus_if.read_or_data_strobe_n),
		.write_or_rw_select_n(bus_if.write_or_rw_select_n), .bus_style_select(bus_if.bus_style_select),
		.data_bus(bus_if.data_bus), .interrupt_out_n(bus_if.interrupt_out_n));

	always #5 core_clk = ~core_clk;

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask

	task automatic hwr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic hrd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// One pin access through the controller; c is the command byte
	task automatic dacc(input logic [12:0] a, input logic [7:0] d, input logic [7:0] c, output logic [7:0] r);
		int i;
		hwr(hbp_pkg::HREG_ADDR_LO, a[7:0]);
		hwr(hbp_pkg::HREG_ADDR_HI, {3'h0, a[12:8]});
		hwr(hbp_pkg::HREG_WDATA, d);
		hwr(hbp_pkg::HREG_CMD, c);
		r = 8'h01;
		for (i = 0; i < 50 && r[0] !== 1'b0; i++)
			hrd(hbp_pkg::HREG_STATUS, r);
		chk("busy", 8'h00, r);
		hrd(hbp_pkg::HREG_RDATA, r);
	endtask

	task automatic pulse(input logic [2:0] m);
		@(posedge core_clk);
		ev <= m;
		@(posedge core_clk);
		ev <= 3'h0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic t_reset;
		hrd(hbp_pkg::HREG_STATUS, q);
		chk("status", 8'h00, q);
		hrd(4'hf, q);
		chk("unmapped host", 8'h00, q);
		chk("int pin", 8'h01, {7'h0, bus_if.interrupt_out_n});
		chk("clk pins", 8'h00, {5'h0, cfg_pins});
		dacc(hbp_pkg::REG_INT_MASK, 8'h00, 8'h02, q);
		chk("mask reset", hbp_pkg::INT_MASK_RST, q);
	endtask

	task automatic t_cfg;
		for (int v = 0; v < 8; v++) begin
			dacc(hbp_pkg::REG_CLK_CFG, 8'(v), 8'h01, q);
			chk("clk pins", 8'(v), {5'h0, cfg_pins});
			dacc(hbp_pkg::REG_CLK_CFG, 8'h00, 8'h02, q);
			chk("clk cfg", 8'(v), q);
		end
		dacc(13'h1002, 8'h01, 8'h01, q);
		dacc(13'h1002, 8'h00, 8'h02, q);
		chk("unmapped dev", 8'h00, q);
		dacc(hbp_pkg::REG_CLK_CFG, 8'h00, 8'h02, q);
		chk("clk cfg kept", 8'h07, q);
	endtask

	// Tick counts over 1024 cycles may differ by one with accumulator phase
	task automatic t_tick;
		logic [7:0]  cfg[3] = '{8'h08, 8'h05, 8'h02};
		logic [17:0] st[3] = '{hbp_pkg::STEP_E1_TO_T1, hbp_pkg::STEP_T1_TO_E1 >> 1, hbp_pkg::STEP_ONE >> 2};
		int          n;
		int          e;
		for (int k = 0; k < 3; k++) begin
			dacc(hbp_pkg::REG_CLK_CFG, cfg[k], 8'h01, q);
			e = (int'(st[k]) * 1024) >> 16;
			n = 0;
			repeat (1024) begin
				@(posedge core_clk);
				if (derived_tick === 1'b1)
					n++;
			end
			total_checks++;
			if (n < e || n > e + 1) begin
				$display("ERROR ticks expected %0d seen %0d", e, n);
				fails++;
			end
		end
	endtask

	// A write under the wrong decode would collide with read data and store the old value
	task automatic t_style;
		hwr(hbp_pkg::HREG_CFG, 8'h01);
		hrd(hbp_pkg::HREG_CFG, q);
		chk("host cfg", 8'h01, q);
		dacc(hbp_pkg::REG_CLK_CFG, 8'h0a, 8'h01, q);
		chk("clk pins style1", 8'h02, {5'h0, cfg_pins});
		dacc(hbp_pkg::REG_CLK_CFG, 8'h00, 8'h02, q);
		chk("clk cfg style1", 8'h0a, q);
		hwr(hbp_pkg::HREG_CFG, 8'h00);
		dacc(hbp_pkg::REG_CLK_CFG, 8'h05, 8'h01, q);
		dacc(hbp_pkg::REG_CLK_CFG, 8'h00, 8'h02, q);
		chk("clk cfg style0", 8'h05, q);
	endtask

	task automatic t_irq;
		logic [7:0] m;
		hwr(hbp_pkg::HREG_IRQ_MASK, 8'h02);
		dacc(hbp_pkg::REG_INT_MASK, 8'h87, 8'h01, q);
		pulse(3'h1);
		chk("int pin", 8'h00, {7'h0, bus_if.interrupt_out_n});
		pulse(3'h2);
		dacc(hbp_pkg::REG_INT_STATUS, 8'h00, 8'h02, q);
		chk("int status", 8'h03, q);
		dacc(hbp_pkg::REG_INT_STATUS, 8'h01, 8'h01, q);
		chk("int pin", 8'h00, {7'h0, bus_if.interrupt_out_n});
		dacc(hbp_pkg::REG_INT_STATUS, 8'h02, 8'h01, q);
		chk("int pin", 8'h01, {7'h0, bus_if.interrupt_out_n});
		hrd(hbp_pkg::HREG_IRQ_STAT, q);
		chk("host irq stat", 8'h03, q);
		chk("irq", 8'h01, {7'h0, irq});
		hwr(hbp_pkg::HREG_IRQ_STAT, 8'h03);
		repeat (3) @(posedge core_clk);
		chk("irq", 8'h00, {7'h0, irq});
		for (int i = 0; i < 3; i++) begin
			m = 8'h01 << i;
			dacc(hbp_pkg::REG_INT_MASK, 8'h80 | (8'h07 & ~m), 8'h01, q);
			pulse(m[2:0]);
			chk("masked pin", 8'h01, {7'h0, bus_if.interrupt_out_n});
			dacc(hbp_pkg::REG_INT_STATUS, 8'h00, 8'h02, q);
			chk("int status", m, q);
			dacc(hbp_pkg::REG_INT_STATUS, m, 8'h01, q);
		end
		dacc(hbp_pkg::REG_INT_MASK, 8'h07, 8'h01, q);
		pulse(3'h7);
		chk("global off", 8'h01, {7'h0, bus_if.interrupt_out_n});
		dacc(hbp_pkg::REG_INT_MASK, 8'h87, 8'h01, q);
		chk("global on", 8'h00, {7'h0, bus_if.interrupt_out_n});
		dacc(hbp_pkg::REG_INT_STATUS, 8'h07, 8'h01, q);
		chk("int pin", 8'h01, {7'h0, bus_if.interrupt_out_n});
	endtask

	task automatic print_verdict;
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		t_reset;
		t_cfg;
		t_tick;
		t_style;
		t_irq;
		print_verdict;
	end

	// Whole run needs well under 40000 cycles
	initial begin
		#400000;
		fails++;
		print_verdict;
	end
endmodule
